// ### logic/acw_defines.vh
`ifndef ACW_DEFINES_VH
`define ACW_DEFINES_VH

// ----------------------------------------------------------------
// instance windows (16-bit word addresses)
// ----------------------------------------------------------------
`define ACW_BASE_FIRST     16'h6400
`define ACW_BASE_SECOND    16'h6420
`define ACW_WIN_MSB        15
`define ACW_WIN_LSB        5
`define ACW_OFF_W          5

// ----------------------------------------------------------------
// register word offsets inside a window
// ----------------------------------------------------------------
`define ACW_OFF_CTL        5'h00
`define ACW_OFF_STS        5'h02
`define ACW_OFF_DAC        5'h06

// ----------------------------------------------------------------
// comparator_control fields
// ----------------------------------------------------------------
`define ACW_CTL_SYNC_BIT   8
`define ACW_CTL_QUAL_MSB   7
`define ACW_CTL_QUAL_LSB   3
`define ACW_CTL_INV_BIT    2
`define ACW_CTL_SRC_BIT    1
`define ACW_CTL_EN_BIT     0
`define ACW_CTL_W          9
`define ACW_CTL_RST        9'h000

// ----------------------------------------------------------------
// reference_level and status fields
// ----------------------------------------------------------------
`define ACW_DAC_W          10
`define ACW_DAC_RST        10'h000
`define ACW_STS_BIT        0

// ----------------------------------------------------------------
// qualification counts (system clocks)
// ----------------------------------------------------------------
`define ACW_QUAL_W         5
`define ACW_QUAL_TOP       5'h0f
`define ACW_QUAL_TOP_RUN   5'h0f
`define ACW_RUN_MAX        5'h1f

`endif

// ### logic/acw_qual_chan.v
`timescale 1ns/1ns
`default_nettype none
`include "acw_defines.vh"

module acw_qual_chan (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  // raw comparator output, asynchronous
  input  wire                    cmp_raw_i,
  // control
  input  wire                    enable_i,
  input  wire                    invert_i,
  input  wire [`ACW_QUAL_W-1:0]  qual_period_i,
  // qualified level, inverted when selected
  output reg                     qual_o
);

  // ----------------------------------------------------------------
  // run length needed for a change
  // ----------------------------------------------------------------
  function [`ACW_QUAL_W-1:0] run_needed;
    input [`ACW_QUAL_W-1:0] q;
    begin
      if (q == {`ACW_QUAL_W{1'b0}}) begin
        run_needed = 5'h01;
      end else if (q >= `ACW_QUAL_TOP) begin
        run_needed = `ACW_QUAL_TOP_RUN;
      end else begin
        run_needed = q + 5'h01;
      end
    end
  endfunction

  reg                    meta_r;
  reg                    sync_r;
  reg                    last_r;
  reg [`ACW_QUAL_W-1:0]  run_r;
  wire                   sample;
  wire [`ACW_QUAL_W-1:0] run_now;

  // two-flop synchroniser; first stage feeds only the second
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= cmp_raw_i;
      sync_r <= meta_r;
    end
  end

  // inversion applied to the synchronised level
  assign sample = sync_r ^ invert_i;

  // length of the current run, counting this clock
  assign run_now = (sample != last_r) ? 5'h01 :
                   (run_r == `ACW_RUN_MAX) ? `ACW_RUN_MAX : run_r + 5'h01;

  // qualifier runs only while the wrapper is enabled
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_r <= 1'b0;
      run_r  <= 5'h00;
      qual_o <= 1'b0;
    end else if (enable_i) begin
      last_r <= sample;
      run_r  <= run_now;
      if (run_now >= run_needed(qual_period_i)) begin
        qual_o <= sample;
      end
    end
  end

endmodule // acw_qual_chan

`default_nettype wire

// ### logic/acw_top.v
`timescale 1ns/1ns
`default_nettype none
`include "acw_defines.vh"

module acw_top (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         resetn_i,
  // register port
  input  wire [15:0]  addr_i,
  input  wire [15:0]  wdata_i,
  input  wire         wr_i,
  input  wire         rd_i,
  output reg  [15:0]  rdata_o,
  // raw comparator outputs, one per instance
  input  wire [1:0]   cmp_raw_i,
  // forwarded comparator outputs
  output wire [1:0]   trip_o,
  output wire [1:0]   gpio_mux_o,
  // analog controls, one per instance
  output reg  [1:0]   power_en_o,
  output reg  [1:0]   inv_src_ext_o,
  output reg  [19:0]  dac_level_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_r;
  reg rst_n_r;

  // asynchronous assert, two-flop release
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // window constants
  // ----------------------------------------------------------------
  localparam [15:0] BASE_FIRST  = `ACW_BASE_FIRST;
  localparam [15:0] BASE_SECOND = `ACW_BASE_SECOND;
  localparam [1:0]  INST_FIRST  = 2'b00;
  localparam [1:0]  INST_SECOND = 2'b01;
  localparam [1:0]  INST_NONE   = 2'b11;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------

  // instance whose window holds the address; none when outside both
  function [1:0] inst_of;
    input [15:0] a;
    begin
      if (a[`ACW_WIN_MSB:`ACW_WIN_LSB] == BASE_FIRST[`ACW_WIN_MSB:`ACW_WIN_LSB]) begin
        inst_of = INST_FIRST;
      end else if (a[`ACW_WIN_MSB:`ACW_WIN_LSB] == BASE_SECOND[`ACW_WIN_MSB:`ACW_WIN_LSB]) begin
        inst_of = INST_SECOND;
      end else begin
        inst_of = INST_NONE;
      end
    end
  endfunction

  // register offset inside a window
  function [`ACW_OFF_W-1:0] off_of;
    input [15:0] a;
    begin
      off_of = a[`ACW_OFF_W-1:0];
    end
  endfunction

  // true when the address selects the given register offset
  function off_is;
    input [15:0]           a;
    input [`ACW_OFF_W-1:0] o;
    begin
      off_is = (off_of(a) == o);
    end
  endfunction

  // ----------------------------------------------------------------
  // read views and output select
  // ----------------------------------------------------------------

  // control word as read: reserved upper bits read zero
  function [15:0] ctl_view;
    input [`ACW_CTL_W-1:0] c;
    begin
      ctl_view = {7'h00, c};
    end
  endfunction

  // status word as read: only bit 0 carries state
  function [15:0] sts_view;
    input s;
    begin
      sts_view = {15'h0000, s};
    end
  endfunction

  // level word as read: upper six bits read zero
  function [15:0] dac_view;
    input [`ACW_DAC_W-1:0] d;
    begin
      dac_view = {6'h00, d};
    end
  endfunction

  // forwarded level: async path is the pin itself, inverted when selected
  function fwd_sel;
    input sync_sel;
    input qual;
    input raw;
    input inv;
    begin
      fwd_sel = sync_sel ? qual : (raw ^ inv);
    end
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------

  // register state
  reg  [`ACW_CTL_W-1:0] ctl_r  [0:1];
  reg  [`ACW_DAC_W-1:0] dac_r  [0:1];
  reg  [1:0]            sts_r;
  wire [1:0]            qual_w;

  // access decode
  wire [1:0]            wr_inst;
  wire [1:0]            hit;
  wire [`ACW_OFF_W-1:0] wr_off;

  // write enables
  wire                  wr_ctl_sel;
  wire                  wr_dac_sel;
  wire [1:0]            wr_ctl;
  wire [1:0]            wr_dac;

  // instance and offset of the current access
  assign hit     = inst_of(addr_i);
  assign wr_off  = off_of(addr_i);
  assign wr_inst = {wr_i && hit == INST_SECOND, wr_i && hit == INST_FIRST};

  // one write enable per register and instance; status and reserved words have none
  assign wr_ctl_sel = off_is(addr_i, `ACW_OFF_CTL);
  assign wr_dac_sel = off_is(addr_i, `ACW_OFF_DAC);
  assign wr_ctl     = wr_inst & {2{wr_ctl_sel}};
  assign wr_dac     = wr_inst & {2{wr_dac_sel}};

  // ----------------------------------------------------------------
  // control field views
  // ----------------------------------------------------------------
  wire [1:0]             en_w;
  wire [1:0]             inv_w;
  wire [1:0]             src_w;
  wire [1:0]             sync_w;

  // qualify periods, one field per instance
  wire [`ACW_QUAL_W-1:0] qual_first_w;
  wire [`ACW_QUAL_W-1:0] qual_second_w;

  // per-instance control bits, first instance in bit 0
  assign en_w          = {ctl_r[1][`ACW_CTL_EN_BIT],   ctl_r[0][`ACW_CTL_EN_BIT]};
  assign inv_w         = {ctl_r[1][`ACW_CTL_INV_BIT],  ctl_r[0][`ACW_CTL_INV_BIT]};
  assign src_w         = {ctl_r[1][`ACW_CTL_SRC_BIT],  ctl_r[0][`ACW_CTL_SRC_BIT]};
  assign sync_w        = {ctl_r[1][`ACW_CTL_SYNC_BIT], ctl_r[0][`ACW_CTL_SYNC_BIT]};

  // period fields feed the qualifiers unchanged
  assign qual_first_w  = ctl_r[0][`ACW_CTL_QUAL_MSB:`ACW_CTL_QUAL_LSB];
  assign qual_second_w = ctl_r[1][`ACW_CTL_QUAL_MSB:`ACW_CTL_QUAL_LSB];

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------

  // control registers; reserved bits have no storage
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctl_r[0] <= `ACW_CTL_RST;
      ctl_r[1] <= `ACW_CTL_RST;
    end else begin
      if (wr_ctl[0]) begin
        ctl_r[0] <= wdata_i[`ACW_CTL_W-1:0];
      end
      if (wr_ctl[1]) begin
        ctl_r[1] <= wdata_i[`ACW_CTL_W-1:0];
      end
    end
  end

  // level registers; bits above the converter width are dropped
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dac_r[0] <= `ACW_DAC_RST;
      dac_r[1] <= `ACW_DAC_RST;
    end else begin
      if (wr_dac[0]) begin
        dac_r[0] <= wdata_i[`ACW_DAC_W-1:0];
      end
      if (wr_dac[1]) begin
        dac_r[1] <= wdata_i[`ACW_DAC_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // comparator channels
  // ----------------------------------------------------------------

  // first instance qualifier
  acw_qual_chan u_qual_first (
    .clk_i         (ref_clk_i),
    .rst_n_i       (rst_n_r),
    .cmp_raw_i     (cmp_raw_i[0]),
    .enable_i      (en_w[0]),
    .invert_i      (inv_w[0]),
    .qual_period_i (qual_first_w),
    .qual_o        (qual_w[0])
  );

  // second instance qualifier
  acw_qual_chan u_qual_second (
    .clk_i         (ref_clk_i),
    .rst_n_i       (rst_n_r),
    .cmp_raw_i     (cmp_raw_i[1]),
    .enable_i      (en_w[1]),
    .invert_i      (inv_w[1]),
    .qual_period_i (qual_second_w),
    .qual_o        (qual_w[1])
  );

  // selected level goes to trip logic and the output multiplexer alike
  assign trip_o[0]     = fwd_sel(sync_w[0], qual_w[0], cmp_raw_i[0], inv_w[0]);
  assign trip_o[1]     = fwd_sel(sync_w[1], qual_w[1], cmp_raw_i[1], inv_w[1]);
  assign gpio_mux_o[0] = trip_o[0];
  assign gpio_mux_o[1] = trip_o[1];

  // ----------------------------------------------------------------
  // status latch
  // ----------------------------------------------------------------

  // holds while the wrapper is disabled
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sts_r <= 2'b00;
    end else begin
      if (en_w[0]) begin
        sts_r[0] <= qual_w[0];
      end
      if (en_w[1]) begin
        sts_r[1] <= qual_w[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------

  // power enables follow the control bit one clock later
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      power_en_o <= 2'b00;
    end else begin
      power_en_o <= en_w;
    end
  end

  // inverting-input source; 1 picks the external pin
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      inv_src_ext_o <= 2'b00;
    end else begin
      inv_src_ext_o <= src_w;
    end
  end

  // both converter levels side by side, second instance on top
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dac_level_o <= 20'h00000;
    end else begin
      dac_level_o <= {dac_r[1], dac_r[0]};
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  reg [15:0] rd_nxt;
  reg        rd_sel;

  // read mux; reserved offsets and unmapped addresses read zero
  always @* begin
    rd_nxt = 16'h0000;
    rd_sel = hit[0];
    if (hit != INST_NONE) begin
      case (wr_off)
        `ACW_OFF_CTL: rd_nxt = ctl_view(ctl_r[rd_sel]);
        `ACW_OFF_STS: rd_nxt = sts_view(sts_r[rd_sel]);
        `ACW_OFF_DAC: rd_nxt = dac_view(dac_r[rd_sel]);
        default:      rd_nxt = 16'h0000;
      endcase
    end
  end

  // read data stand for one cycle after the strobe
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // acw_top

`default_nettype wire

// ### dv/acw_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module acw_checker (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [1:0]  trip_o,
  input wire logic [1:0]  gpio_mux_o,
  input wire logic [1:0]  power_en_o,
  input wire logic [1:0]  inv_src_ext_o,
  input wire logic [19:0] dac_level_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_copy; gpio_mux_o == trip_o; endproperty
  property p_idle; !rd_i |=> rdata_o == 16'h0; endproperty
  property p_ctl; rd_i && addr_i == 16'h6400 |=> rdata_o[15:9] == 7'h0; endproperty
  property p_sts; rd_i && addr_i == 16'h6402 |=> rdata_o[15:1] == 15'h0; endproperty
  property p_dac;
    wr_i && addr_i == 16'h6406 |-> ##2 dac_level_o[9:0] == $past(wdata_i[9:0], 2);
  endproperty
  property p_dac2;
    wr_i && addr_i == 16'h6426 |-> ##2 dac_level_o[19:10] == $past(wdata_i[9:0], 2);
  endproperty
  property p_en;
    wr_i && addr_i == 16'h6400 |-> ##2 power_en_o[0] == $past(wdata_i[0], 2);
  endproperty
  property p_src;
    wr_i && addr_i == 16'h6400 |-> ##2 inv_src_ext_o[0] == $past(wdata_i[1], 2);
  endproperty
  a_copy: assert property (p_copy) else $error("gpio copy differs");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_ctl: assert property (p_ctl) else $error("control upper bits set");
  a_sts: assert property (p_sts) else $error("status upper bits set");
  a_dac: assert property (p_dac) else $error("level one wrong");
  a_dac2: assert property (p_dac2) else $error("level two wrong");
  a_en: assert property (p_en) else $error("power enable wrong");
  a_src: assert property (p_src) else $error("source select wrong");
  c_wr: cover property (wr_i && addr_i == 16'h6400);
  c_rd: cover property (rd_i && addr_i == 16'h6402);
  c_trip: cover property ($rose(trip_o[0]));
endmodule // acw_checker
bind acw_top acw_checker chk_i (.*);
`default_nettype wire

// ### dv/acw_trip_sink.sv
`timescale 1ns/1ns
`default_nettype none
module acw_trip_sink (
  input wire logic [1:0] trip_i,
  input wire logic [1:0] gpio_i,
  input wire logic       clk_i,
  output var logic [1:0] seen_o
);
  // latch trips that both routes carry
  initial seen_o = 2'h0;
  always @(posedge clk_i) seen_o <= seen_o | (trip_i & gpio_i);
endmodule // acw_trip_sink
`default_nettype wire

// ### dv/tb_acw_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_acw_top;
  logic        ref_clk_i = 0;
  logic        resetn_i = 0;
  logic        wr_i = 0;
  logic        rd_i = 0;
  logic [15:0] addr_i = 16'h0;
  logic [15:0] wdata_i = 16'h0;
  logic [1:0]  cmp_raw_i = 2'h0;
  wire [15:0]  rdata_o;
  wire [1:0]   trip_o, gpio_mux_o, power_en_o, inv_src_ext_o, seen;
  wire [19:0]  dac_level_o;
  int          n_errors = 0;
  int          tests_run = 0;
  int          k;
  logic [15:0] v;
  // clock
  always #50 ref_clk_i = ~ref_clk_i;
  acw_top dut (.ref_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cmp_raw_i, .trip_o, .gpio_mux_o, .power_en_o, .inv_src_ext_o, .dac_level_o);
  acw_trip_sink sink (.clk_i(ref_clk_i), .trip_i(trip_o), .gpio_i(gpio_mux_o), .seen_o(seen));
  task results;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [19:0] s, e, input string nm);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [15:0] a, d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task rchk(input logic [15:0] a, e, input string nm);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, nm);
  endtask
  // run length needed before the qualified output follows
  task lat(input logic [4:0] p, input int n);
    wr(16'h6400, {7'h0, 1'b1, p, 3'b001});
    @(posedge ref_clk_i);
    cmp_raw_i <= 2'h0;
    repeat (24) @(posedge ref_clk_i);
    if (n > 1) begin
      cmp_raw_i <= 2'h1;
      repeat (n - 1) @(posedge ref_clk_i);
      cmp_raw_i <= 2'h0;
      repeat (n + 4) @(posedge ref_clk_i);
      #1;
      chk(trip_o[0], 1'b0, "short pulse");
      @(posedge ref_clk_i);
    end
    cmp_raw_i <= 2'h1;
    for (k = 1; k < 40; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (trip_o[0] === 1'b1) break;
    end
    chk(k, 2 + n, "qualify delay");
    if (k == 40) results();
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rchk(16'h6400, 16'h0, "control reset");
    rchk(16'h6406, 16'h0, "level reset");
    $display("reset test done");
    wr(16'h6400, 16'hffff);
    rchk(16'h6400, 16'h01ff, "control");
    chk(power_en_o[0], 1'b1, "power");
    chk(inv_src_ext_o[0], 1'b1, "source");
    wr(16'h6406, 16'hffff);
    rchk(16'h6406, 16'h03ff, "level");
    chk(dac_level_o[9:0], 10'h3ff, "level out");
    wr(16'h6426, 16'h0155);
    rchk(16'h6426, 16'h0155, "level two");
    chk(dac_level_o[19:10], 10'h155, "level two out");
    wr(16'h6401, 16'hffff);
    rchk(16'h6401, 16'h0, "reserved");
    rchk(16'h6440, 16'h0, "unmapped");
    $display("register test done");
    wr(16'h6400, 16'h0001);
    @(posedge ref_clk_i);
    cmp_raw_i <= 2'h1;
    #1;
    chk(trip_o[0], 1'b1, "async path");
    wr(16'h6400, 16'h0005);
    chk(trip_o[0], 1'b0, "inverted");
    chk(seen[0], 1'b1, "trip seen");
    wr(16'h6420, 16'h0007);
    chk(power_en_o[1], 1'b1, "power two");
    chk(inv_src_ext_o[1], 1'b1, "source two");
    chk(trip_o[1], 1'b1, "inverted two");
    chk(seen[1], 1'b1, "trip two seen");
    $display("path test done");
    lat(5'h00, 1);
    lat(5'h01, 2);
    lat(5'h02, 3);
    lat(5'h0f, 15);
    wr(16'h6402, 16'h0);
    rchk(16'h6402, 16'h0001, "status");
    wr(16'h6400, 16'h0100);
    @(posedge ref_clk_i);
    cmp_raw_i <= 2'h0;
    repeat (24) @(posedge ref_clk_i);
    rchk(16'h6402, 16'h0001, "frozen status");
    chk(trip_o[0], 1'b1, "frozen output");
    $display("qualify test done");
    results();
  end
endmodule // tb_acw_top
`default_nettype wire
